// file: drive_status_defines.svh
// Behaviour
// (RQ1) after reset the menu sits on the monitoring function.
// (RQ2) enabled low and no error: display shows the idle banner.
// (RQ3) enabled and no error: display shows the running banner.
// (RQ4) running banner leftmost digit shows node address one to sixteen; the code uses the two leftmost digits, tens then units.
// (RQ5) rightmost digit lights one segment, advancing with rotation direction.
// (RQ6) error latched while another function is selected: display flashes.
// (RQ7) every error is recorded; its code is shown on the monitoring function.
// (RQ8) error state flashes the error prefix and the two-digit code.
// (RQ9) a latched error stops the power stage and raises fault, except excluded.
// (RQ10) overload integral, servo error, forward and reverse limits never stop.
// (RQ11) enable low then high clears latched errors.
// (RQ12) errors whose cause persists stay latched after the clear.
// (RQ13) increment key steps function up, decrement key steps it down.
// (RQ14) choose enters selection, keys pick, choose again shows the value.
// (RQ15) while a value is shown, keys change the value.
// (RQ16) display is five seven-segment digits.
// (RQ17) codes 01 to 07: overvoltage to supply phase loss.
// (RQ18) lowest latched code shown first; flash rate a few hertz.
`ifndef DRIVE_STATUS_DEFINES_SVH
`define DRIVE_STATUS_DEFINES_SVH
`define CLK_MHZ        125
`define FLASH_HALF_MS  250
`define FLASH_HALF_CYC (`FLASH_HALF_MS * `CLK_MHZ * 1000)
`define DIGITS         5
`define ERR_LINES      16
`define ERR_NONSTOP    16'he004
`define MONITOR_FUNC   8'h28
`define FUNC_MAX       8'h63
`define SEG_BLANK      7'h00
`define SEG_PREFIX     7'h79
`define SEG_DASH       7'h40
`define SEG_D          7'h5e
`define SEG_I          7'h10
`define SEG_S          7'h6d
`define SEG_A          7'h77
`define SEG_B          7'h7c
`define SEG_G          7'h3d
`define SEG_O          7'h3f
`define SEG_F          7'h71
`endif

// file: drive_status_pkg.sv
package drive_status_pkg;
  typedef enum logic [1:0] {
    menu_monitor,
    menu_select,
    menu_value
  } menu_type;
  typedef logic [6:0] seg_type;
endpackage

// file: seg_font_if.sv
`timescale 1ns/1ps
`default_nettype none
interface seg_font_if;
  logic [3:0]                   nibble;
  drive_status_pkg::seg_type    glyph;
  modport user (output nibble, input glyph);
  modport font (input nibble, output glyph);
endinterface
`default_nettype wire

// file: seg_font.sv
`timescale 1ns/1ps
`default_nettype none
module seg_font (
  seg_font_if.font f
);
  always_comb begin
    case (f.nibble)
      4'h0: f.glyph = 7'h3f;
      4'h1: f.glyph = 7'h06;
      4'h2: f.glyph = 7'h5b;
      4'h3: f.glyph = 7'h4f;
      4'h4: f.glyph = 7'h66;
      4'h5: f.glyph = 7'h6d;
      4'h6: f.glyph = 7'h7d;
      4'h7: f.glyph = 7'h07;
      4'h8: f.glyph = 7'h7f;
      4'h9: f.glyph = 7'h6f;
      default: f.glyph = 7'h00;
    endcase
  end
endmodule
`default_nettype wire

// file: drive_status_fault_display.sv
`timescale 1ns/1ps
`default_nettype none
`include "drive_status_defines.svh"
module drive_status_fault_display #(
  parameter int unsigned flash_half_cyc = `FLASH_HALF_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic [15:0] err_cause,
  input  wire logic [3:0]  node_addr,
  input  wire logic        rotor_step,
  input  wire logic        rotor_dir,
  input  wire logic        key_choose,
  input  wire logic        key_up,
  input  wire logic        key_down,
  output logic             stage_run,
  output logic             fault,
  output logic [15:0]      err_latched,
  output logic [7:0]       func_num,
  output logic [7:0]       func_value,
  output logic             value_shown,
  output logic [6:0]       seg0,
  output logic [6:0]       seg1,
  output logic [6:0]       seg2,
  output logic [6:0]       seg3,
  output logic [6:0]       seg4,
  output logic [4:0]       dot
);
  // seg4 is the leftmost digit, seg0 the rightmost
  drive_status_pkg::menu_type menu;
  drive_status_pkg::menu_type next_menu;
  logic [15:0] next_err;
  logic        en_d;
  logic [7:0]  next_func;
  logic [7:0]  next_value;
  logic [2:0]  rot;
  logic [2:0]  next_rot;
  logic [31:0] flash_cnt;
  logic [31:0] next_flash_cnt;
  logic        flash_on;
  logic        next_flash_on;
  logic [6:0]  next_seg [`DIGITS];
  logic [6:0]  seg_q [`DIGITS];
  logic        k_choose_d;
  logic        k_up_d;
  logic        k_down_d;
  logic        p_choose;
  logic        p_up;
  logic        p_down;
  logic        reenable;
  logic        any_err;
  logic [4:0]  low_code;
  seg_font_if  fa ();
  seg_font_if  fb ();

  seg_font u_font_a (.f(fa));
  seg_font u_font_b (.f(fb));

  assign p_choose = key_choose & ~k_choose_d;
  assign p_up     = key_up & ~k_up_d;
  assign p_down   = key_down & ~k_down_d;
  assign reenable = enable & ~en_d;
  assign any_err  = |err_latched;

  // latch: set from cause wins over the clear on re-enable
  always_comb begin
    next_err = err_latched | err_cause; // [RQ7]
    if (reenable) begin
      next_err = err_cause; // [RQ11] [RQ12]
    end
  end

  // lowest latched code first
  always_comb begin
    low_code = 5'h00;
    for (int i = `ERR_LINES - 1; i >= 0; i--) begin
      if (err_latched[i]) begin
        low_code = 5'(i + 1); // [RQ18]
      end
    end
  end

  always_comb begin
    next_menu  = menu;
    next_func  = func_num;
    next_value = func_value;
    case (menu)
      drive_status_pkg::menu_monitor: begin
        if (p_choose) begin
          next_menu = drive_status_pkg::menu_select; // [RQ14]
        end
      end
      drive_status_pkg::menu_select: begin
        if (p_up && func_num != `FUNC_MAX) begin
          next_func = func_num + 8'h01; // [RQ13]
        end else if (p_down && func_num != 8'h00) begin
          next_func = func_num - 8'h01; // [RQ13]
        end
        if (p_choose) begin
          next_menu = (func_num == `MONITOR_FUNC) ?
                      drive_status_pkg::menu_monitor :
                      drive_status_pkg::menu_value; // [RQ14]
        end
      end
      drive_status_pkg::menu_value: begin
        if (p_up) begin
          next_value = func_value + 8'h01; // [RQ15]
        end else if (p_down) begin
          next_value = func_value - 8'h01; // [RQ15]
        end
        if (p_choose) begin
          next_menu = drive_status_pkg::menu_select;
        end
      end
      default: next_menu = drive_status_pkg::menu_monitor;
    endcase
  end

  // one lit outer segment walking with rotor steps
  always_comb begin
    next_rot = rot;
    if (rotor_step) begin
      if (rotor_dir) begin
        next_rot = (rot == 3'h5) ? 3'h0 : rot + 3'h1; // [RQ5]
      end else begin
        next_rot = (rot == 3'h0) ? 3'h5 : rot - 3'h1; // [RQ5]
      end
    end
  end

  always_comb begin
    next_flash_cnt = flash_cnt + 32'h1;
    next_flash_on  = flash_on;
    if (flash_cnt >= flash_half_cyc - 1) begin
      next_flash_cnt = 32'h0;
      next_flash_on  = ~flash_on; // [RQ18]
    end
  end

  // node address shown as 1..16: node_addr 0 means node 1
  always_comb begin
    logic [4:0] node;
    node = {1'b0, node_addr} + 5'h01;
    fa.nibble = 4'hf;
    fb.nibble = 4'hf;
    for (int d = 0; d < `DIGITS; d++) begin
      next_seg[d] = `SEG_BLANK;
    end
    if (menu == drive_status_pkg::menu_monitor) begin
      if (any_err) begin
        fa.nibble = 4'((low_code / 5'd10) % 5'd10);
        fb.nibble = 4'(low_code % 5'd10);
        if (flash_on) begin
          next_seg[4] = `SEG_PREFIX; // [RQ8]
          next_seg[3] = `SEG_PREFIX;
          next_seg[2] = `SEG_DASH;
          next_seg[1] = fa.glyph; // [RQ7] [RQ17]
          next_seg[0] = fb.glyph;
        end
      end else if (enable) begin
        fa.nibble = 4'(node % 5'd10);
        // leading zero kept so the banner always reads two node digits
        next_seg[4] = (node > 5'd9) ? 7'h06 : 7'h3f; // [RQ4]
        next_seg[3] = fa.glyph; // [RQ3] [RQ4]
        next_seg[2] = `SEG_G;
        next_seg[1] = `SEG_O;
        next_seg[0] = 7'(7'h01 << rot); // [RQ5]
      end else begin
        next_seg[4] = `SEG_D; // [RQ2]
        next_seg[3] = `SEG_I;
        next_seg[2] = `SEG_S;
        next_seg[1] = `SEG_A;
        next_seg[0] = `SEG_B;
      end
    end else begin
      fa.nibble = 4'((func_num / 8'd10) % 8'd10);
      fb.nibble = 4'(func_num % 8'd10);
      if (menu == drive_status_pkg::menu_value) begin
        fa.nibble = 4'((func_value / 8'd10) % 8'd10);
        fb.nibble = 4'(func_value % 8'd10);
      end
      if (!any_err || flash_on) begin // [RQ6]
        next_seg[4] = `SEG_F;
        next_seg[3] = `SEG_F;
        next_seg[2] = `SEG_DASH;
        next_seg[1] = fa.glyph;
        next_seg[0] = fb.glyph;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      menu        <= drive_status_pkg::menu_monitor; // [RQ1]
      func_num    <= `MONITOR_FUNC; // [RQ1]
      func_value  <= 8'h00;
      err_latched <= 16'h0000;
      en_d        <= 1'b0;
      rot         <= 3'h0;
      flash_cnt   <= 32'h0;
      flash_on    <= 1'b1;
      k_choose_d  <= 1'b0;
      k_up_d      <= 1'b0;
      k_down_d    <= 1'b0;
      for (int d = 0; d < `DIGITS; d++) begin
        seg_q[d] <= `SEG_BLANK;
      end
    end else begin
      menu        <= next_menu;
      func_num    <= next_func;
      func_value  <= next_value;
      err_latched <= next_err;
      en_d        <= enable;
      rot         <= next_rot;
      flash_cnt   <= next_flash_cnt;
      flash_on    <= next_flash_on;
      k_choose_d  <= key_choose;
      k_up_d      <= key_up;
      k_down_d    <= key_down;
      for (int d = 0; d < `DIGITS; d++) begin
        seg_q[d] <= next_seg[d]; // [RQ16]
      end
    end
  end

  // fault is combinational so the stage stops in the latching cycle
  assign fault = |(err_latched & ~`ERR_NONSTOP); // [RQ9] [RQ10]
  assign stage_run   = enable & ~fault; // [RQ9]
  assign value_shown = (menu == drive_status_pkg::menu_value);
  assign seg4 = seg_q[4];
  assign seg3 = seg_q[3];
  assign seg2 = seg_q[2];
  assign seg1 = seg_q[1];
  assign seg0 = seg_q[0];
  assign dot  = (menu == drive_status_pkg::menu_monitor && !any_err &&
                 enable) ? 5'h08 : 5'h00; // [RQ3]

  a_err_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    err_cause[0] |=> err_latched[0]) // [RQ7]
    else $error("error not latched");
  a_err_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (err_latched[1] && !reenable) |=> err_latched[1]) // [RQ7]
    else $error("error lost without re-enable");
  a_clear_reen: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reenable && err_cause == 16'h0) |=> !any_err) // [RQ11]
    else $error("errors not cleared on re-enable");
  a_persist_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reenable && err_cause[4]) |=> err_latched[4]) // [RQ12]
    else $error("persisting error dropped");
  a_fault_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    err_cause[0] |=> fault && !stage_run) // [RQ9]
    else $error("stage runs during fault");
  a_nonstop_class: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (err_latched == 16'h0004 || err_latched == 16'h2000 ||
      err_latched == 16'h4000 || err_latched == 16'h8000) |-> !fault) // [RQ10]
    else $error("excluded error raised fault");
  sequence s_choose_up;
    (menu == drive_status_pkg::menu_select) && p_up && !p_choose &&
      func_num != `FUNC_MAX;
  endsequence
  a_menu_up: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_choose_up |=> func_num == $past(func_num) + 8'h01) // [RQ13]
    else $error("function did not step up");
  a_value_down: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (value_shown && p_down && !p_up) |=>
      func_value == $past(func_value) - 8'h01) // [RQ15]
    else $error("value did not step down");
  a_idle_show: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (menu == drive_status_pkg::menu_monitor && !any_err && !enable)
      |=> seg4 == `SEG_D) // [RQ2]
    else $error("idle banner missing");
  a_err_prefix: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (menu == drive_status_pkg::menu_monitor && any_err && flash_on)
      |=> seg4 == `SEG_PREFIX) // [RQ8]
    else $error("error prefix missing");
  sequence s_err_dark;
    (menu == drive_status_pkg::menu_monitor) && any_err && !flash_on;
  endsequence
  a_err_dark: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_err_dark |=> seg4 == `SEG_BLANK && seg0 == `SEG_BLANK) // [RQ8]
    else $error("error display not dark");
  a_run_banner: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (menu == drive_status_pkg::menu_monitor && !any_err && enable)
      |=> seg2 == `SEG_G && seg1 == `SEG_O) // [RQ3]
    else $error("running banner missing");
  a_rot_single: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (menu == drive_status_pkg::menu_monitor && !any_err && enable)
      |=> $countones(seg0) == 1) // [RQ5]
    else $error("rotor digit not one segment");
  a_flash_menu: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (menu != drive_status_pkg::menu_monitor && any_err && !flash_on)
      |=> seg4 == `SEG_BLANK) // [RQ6]
    else $error("menu display not flashing");
  a_func_down: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (menu == drive_status_pkg::menu_select && p_down && !p_up &&
      func_num != 8'h00)
      |=> func_num == $past(func_num) - 8'h01) // [RQ13]
    else $error("function did not step down");
  sequence s_pick_func;
    (menu == drive_status_pkg::menu_select) && p_choose &&
      func_num != `MONITOR_FUNC;
  endsequence
  a_choose_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_pick_func |=> value_shown) // [RQ14]
    else $error("choose did not show the value");
  a_low_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (menu == drive_status_pkg::menu_monitor && flash_on &&
      err_latched[1] && !err_latched[0]) |=> seg0 == 7'h5b) // [RQ18]
    else $error("lowest error code not shown");
endmodule
`default_nettype wire

// file: panel_partner.sv
`timescale 1ns/1ps
`default_nettype none
module panel_partner (
  input  wire logic       ref_clk,
  input  wire logic [2:0] press,
  input  wire logic       run,
  input  wire logic       clr,
  output logic [2:0]      keys,
  output logic            enable,
  output logic            busy
);
  logic [2:0] cnt  = 3'h0;
  logic [2:0] held = 3'h0;
  // key high two cycles then low two, so each press is one clean edge
  always @(posedge ref_clk) begin
    if (cnt == 3'h0 && (press != 3'h0 || clr)) begin
      cnt  <= 3'h4;
      held <= press;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
  assign keys   = (cnt > 3'h2) ? held : 3'h0;
  // enable dropped two cycles, then raised again
  assign enable = run & ~(cnt > 3'h2 && held == 3'h0);
  assign busy   = cnt != 3'h0;
endmodule
`default_nettype wire

// file: drive_status_fault_display_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "drive_status_defines.svh"
module drive_status_fault_display_tb;
  typedef struct {int code; logic flt;} row_type;
  row_type rows [10] = '{'{1,1}, '{2,1}, '{3,0}, '{4,1}, '{5,1},
    '{6,1}, '{7,1}, '{14,0}, '{15,0}, '{16,0}};
  logic [6:0] font [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
    7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  logic ref_clk = 1'b0, rst_n = 1'b0, run = 1'b0, clr = 1'b0;
  logic rotor_step = 1'b0, rotor_dir = 1'b1;
  logic [2:0] press = 3'h0, keys;
  logic [15:0] err_cause = 16'h0, err_latched;
  logic [3:0] node_addr = 4'h0;
  logic enable, busy, stage_run, fault, value_shown;
  logic [7:0] func_num, func_value;
  logic [6:0] seg0, seg1, seg2, seg3, seg4, g0;
  logic [4:0] dot;
  int num_errors = 0, n_compared = 0;
  always #4 ref_clk = ~ref_clk;
  panel_partner panel (.ref_clk(ref_clk), .press(press), .run(run),
    .clr(clr), .keys(keys), .enable(enable), .busy(busy));
  drive_status_fault_display #(.flash_half_cyc(4)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .enable(enable),
    .err_cause(err_cause), .node_addr(node_addr),
    .rotor_step(rotor_step), .rotor_dir(rotor_dir),
    .key_choose(keys[0]), .key_up(keys[1]), .key_down(keys[2]),
    .stage_run(stage_run), .fault(fault), .err_latched(err_latched),
    .func_num(func_num), .func_value(func_value),
    .value_shown(value_shown), .seg0(seg0), .seg1(seg1), .seg2(seg2),
    .seg3(seg3), .seg4(seg4), .dot(dot));
  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic look(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // the partner paces key edges and the clear sequence
  task automatic act(logic [2:0] p, logic c);
    int i;
    @(posedge ref_clk);
    press <= p;
    clr   <= c;
    @(posedge ref_clk);
    press <= 3'h0;
    clr   <= 1'b0;
    // busy only rises after the partner has taken the request
    @(posedge ref_clk);
    i = 0;
    while (busy && i < 10) begin
      @(posedge ref_clk);
      i++;
    end
    look(2);
  endtask
  task automatic blink();
    int i;
    i = 0;
    while (seg4 !== 7'h00 && i < 20) begin look(1); i++; end
    chk("dark", 16'h0, {9'h0, seg4});
    while (seg4 === 7'h00 && i < 40) begin look(1); i++; end
    chk("lit", 16'h1, {15'h0, seg4 !== 7'h00});
  endtask
  task automatic code(int c);
    blink();
    chk("pfx", {2{1'b0, `SEG_PREFIX}}, {1'b0, seg4, 1'b0, seg3});
    chk("dash", {9'h0, `SEG_DASH}, {9'h0, seg2});
    chk("code", {2'h0, font[c / 10], font[c % 10]}, {2'h0, seg1, seg0});
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    look(3);
    chk("func", 16'h28, {8'h0, func_num});
    chk("idle", {2'h0, `SEG_D, `SEG_I}, {2'h0, seg4, seg3});
    chk("idle2", {`SEG_S, `SEG_A, 2'h0}, {seg2, seg1, 2'h0});
    chk("idle3", {9'h0, `SEG_B}, {9'h0, seg0});
    @(posedge ref_clk);
    run <= 1'b1;
    look(3);
    chk("go", {2'h0, `SEG_G, `SEG_O}, {2'h0, seg2, seg1});
    chk("node1", {2'h0, 7'h3f, 7'h06}, {2'h0, seg4, seg3});
    chk("ndot", 16'h1, {15'h0, dot[3]});
    chk("run", 16'h1, {15'h0, stage_run});
    @(posedge ref_clk);
    node_addr <= 4'hf;
    look(2);
    chk("node16", {2'h0, 7'h06, 7'h7d}, {2'h0, seg4, seg3});
    g0 = seg0;
    chk("one", 16'h1, {15'h0, $countones(g0) == 1});
    for (int d = 1; d >= 0; d--) begin
      @(posedge ref_clk);
      rotor_dir  <= d[0];
      rotor_step <= 1'b1;
      @(posedge ref_clk);
      rotor_step <= 1'b0;
      look(2);
      chk("step", {15'h0, d[0]}, {15'h0, seg0 != g0});
    end
    foreach (rows[r]) begin
      @(posedge ref_clk);
      err_cause <= 16'h1 << (rows[r].code - 1);
      look(2);
      chk("latch", err_cause, err_latched);
      chk("fault", {15'h0, rows[r].flt}, {15'h0, fault});
      chk("stage", {15'h0, ~rows[r].flt}, {15'h0, stage_run});
      code(rows[r].code);
      @(posedge ref_clk);
      err_cause <= 16'h0;
      act(3'h0, 1'b1);
      chk("clear", 16'h0, err_latched);
    end
    @(posedge ref_clk);
    err_cause <= 16'h0012;
    look(2);
    code(2);
    act(3'h0, 1'b1);
    chk("persist", 16'h0012, err_latched);
    act(3'h1, 1'b0);
    chk("sel", 16'h0, {15'h0, value_shown});
    blink();
    chk("ff", {9'h0, `SEG_F}, {9'h0, seg4});
    act(3'h2, 1'b0);
    chk("up", 16'h29, {8'h0, func_num});
    act(3'h4, 1'b0);
    chk("down", 16'h28, {8'h0, func_num});
    act(3'h2, 1'b0);
    act(3'h1, 1'b0);
    chk("val", 16'h1, {15'h0, value_shown});
    act(3'h2, 1'b0);
    chk("inc", 16'h1, {8'h0, func_value});
    act(3'h4, 1'b0);
    chk("dec", 16'h0, {8'h0, func_value});
    act(3'h1, 1'b0);
    act(3'h4, 1'b0);
    act(3'h1, 1'b0);
    chk("mon", 16'h0, {15'h0, value_shown});
    code(2);
    conclude();
  end
endmodule
`default_nettype wire
